// ==== tlptx_fifo.sv ====
// holds the shared constants of the transmit stream sink and its buffer.
// assumes one clock and a synchronous active high reset on the same clock.
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// constants
// ****************************************************************
package tlptx_pkg;
  localparam int TLPTX_RDY_LATENCY = 2;   // sender valid lags ready
  localparam int TLPTX_RDY_MARGIN = TLPTX_RDY_LATENCY + 2;
  localparam int TLPTX_DEF_WIDTH = 128;
  localparam int TLPTX_DEF_DEPTH = 16;
  localparam int TLPTX_SEG_BITS = 128;    // segment of the wide bus
  localparam int TLPTX_FMT4_POS = 29;     // dword0 bit: four dword header
  localparam int TLPTX_TYPE_POS = 27;     // dword0 bits 28:27 of type
  localparam logic [1:0] TLPTX_MSG_TYPE = 2'h2;
  localparam int TLPTX_ADDR_POS = 2;      // address bit 2: unaligned
  localparam logic TLPTX_RST_READY = 1'h0;
  localparam logic TLPTX_RST_FLAG = 1'h0;
endpackage

// ****************************************************************
// shift buffer: head entry is always slot 0, so outputs are flops
// ****************************************************************
module tlptx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = tlptx_pkg::TLPTX_DEF_DEPTH,
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic valid_q;
  wire push = in_valid && in_ready;
  wire pop = valid_q && out_ready;

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("tlptx_fifo: depth must be at least 2");
  end

  // occupancy and handshakes; full from the count, empty from a flag registered from the next count
  assign in_ready = (count_q != CW'(DEPTH));
  assign out_valid = valid_q;
  assign out_data = mem_q[0];
  assign level = count_q;
  assign count_d = count_q + CW'(push) - CW'(pop);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      valid_q <= 1'h0;
    end else begin
      count_q <= count_d;
      valid_q <= (count_d != '0);
    end
  end

  // data slots carry no reset; validity comes from the count
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        if (push && i == int'(count_q) - 1) begin
          mem_q[i] <= in_data;
        end else if (i < DEPTH - 1) begin
          mem_q[i] <= mem_q[i+1];
        end
      end else if (push && i == int'(count_q)) begin
        mem_q[i] <= in_data;
      end
    end
  end

  // a push into a full buffer would lose a word
  property p_no_overflow;
    @(posedge clk) disable iff (rst) in_valid |-> in_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("buffer written while full");
endmodule

`default_nettype wire

// ==== tlptx_sender_model.sv ====
// sender model: application logic feeding the transmit stream sink.
// assumes a 128 bit bus, one clock and a ready latency of two cycles.
`timescale 1ns/1ns
`default_nettype none

// ********
// sender model
// ********
module tlptx_sender_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ready,
  output logic [127:0] word,
  output logic first,
  output logic last,
  output logic empty,
  output logic poison,
  output logic valid
);
  logic [131:0] beats[$]; // first, last, empty, poison, word
  logic [1:0] rdy_q;
  bit rude = 1'h0; // ignores ready, only for overrun tests
  int gap = 0; // idle cycles after each packet end
  int idle = 0;
  // ready history: a beat may only follow ready of two cycles ago
  always @(posedge clk) rdy_q <= rst ? 2'h0 : {rdy_q[0], ready};
  // drive on the falling edge; a paused word is held, not changed
  always @(negedge clk) begin
    if (beats.size() > 0 && idle == 0 && (rdy_q[1] || rude)) begin
      {first, last, empty, poison, word} = beats.pop_front();
      valid = 1'h1; // packets open in the low half
      idle = last ? gap : 0;
    end else begin
      valid = 1'h0;
      if (idle > 0) idle--;
      // released bus wanders so stale data never looks valid
      if (beats.size() == 0) word = ~word;
    end
  end
  initial begin
    {first, last, empty, poison, valid} = 5'h0;
    word = 128'h0;
  end
endmodule
`default_nettype wire

// ==== tlptx_stream_sink.sv ====
// holds the transmit stream sink: framing check, header decode, ready
// with two cycle latency, and a buffer towards the transaction layer.
// assumes the sender and the credit logic run on CLK.
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// transmit stream sink
// ****************************************************************
// Summary of operation
// - three or four dword headers; messages use four dwords
// - address bit 2 set means not quadword aligned
// - deasserting ready is the only backpressure
// - 64-bit: start right after end accepted
// - 128-bit: idle cycles between packets tolerated
// - empty set at end when only low half
// - multi mode: start either half, share cycle
// - ready low from the cycle after credits are exhausted
module tlptx_stream_sink #(
  parameter int WIDTH = tlptx_pkg::TLPTX_DEF_WIDTH,
  parameter int DEPTH = tlptx_pkg::TLPTX_DEF_DEPTH,
  parameter bit MULTI = 1'b0,
  localparam int SEGS = (WIDTH == 256) ? 2 : 1,
  localparam int EW = (WIDTH == 256) ? 2 : 1,
  localparam int FW = WIDTH + 2 * SEGS + EW + 1
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [WIDTH-1:0] TX_STREAM_WORD,
  input wire logic [SEGS-1:0] TX_PACKET_FIRST,
  input wire logic [SEGS-1:0] TX_PACKET_LAST,
  input wire logic TX_WORD_VALID,
  input wire logic [EW-1:0] TX_UPPER_HALF_UNUSED,
  input wire logic TX_PACKET_POISON,
  output logic TX_ACCEPT_READY,
  input wire logic CREDIT_EXHAUSTED,
  output logic [WIDTH-1:0] OUT_WORD,
  output logic [SEGS-1:0] OUT_FIRST,
  output logic [SEGS-1:0] OUT_LAST,
  output logic [EW-1:0] OUT_EMPTY,
  output logic OUT_POISON,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic ADDR_UNALIGNED,
  output logic FRAME_FAULT
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int MARGIN = tlptx_pkg::TLPTX_RDY_MARGIN;

  if (!(WIDTH == 64 || WIDTH == 128 || WIDTH == 256) || DEPTH <= MARGIN
      || (MULTI && WIDTH != 256)) begin : g_chk
    $error("tlptx_stream_sink: unsupported width, depth or mode");
  end

  logic ready_q;
  logic [1:0] rdy_pipe_q;
  logic in_pkt_q;
  logic in_pkt_d;
  logic hdr_pend_q;
  logic hdr4_q;
  logic unal_q;
  logic fault_q;
  logic fault_d;
  logic [CW-1:0] level;
  logic fifo_in_ready;
  logic [FW-1:0] head;

  // ****************************************************************
  // ready with latency: a beat is legal two cycles after ready
  // ****************************************************************
  // margin covers the beat being granted plus those promised by the three ready cycles in flight
  wire space_ok = (int'(level) <= DEPTH - MARGIN);
  wire ready_d = space_ok && !CREDIT_EXHAUSTED;
  wire allowed = rdy_pipe_q[tlptx_pkg::TLPTX_RDY_LATENCY-1];
  wire take = TX_WORD_VALID && allowed;
  wire overrun = TX_WORD_VALID && !allowed;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ready_q <= tlptx_pkg::TLPTX_RST_READY;
      rdy_pipe_q <= '0;
    end else begin
      ready_q <= ready_d;
      rdy_pipe_q <= {rdy_pipe_q[0], ready_q};
    end
  end

  // ****************************************************************
  // header decode on the segment that opens a packet
  // ****************************************************************
  wire sop_any = |TX_PACKET_FIRST;
  wire eop_any = |TX_PACKET_LAST;
  wire open_hi = (SEGS == 2) && !TX_PACKET_FIRST[0];
  wire [255:0] wide = 256'(TX_STREAM_WORD);
  wire [255:0] seg_word = open_hi ? (wide >> tlptx_pkg::TLPTX_SEG_BITS)
                                  : wide;
  wire [31:0] dw0 = seg_word[31:0];
  wire is4 = dw0[tlptx_pkg::TLPTX_FMT4_POS];
  wire is_msg = dw0[tlptx_pkg::TLPTX_TYPE_POS +: 2] ==
                tlptx_pkg::TLPTX_MSG_TYPE;
  // wide buses see the address dword in the opening beat, 64-bit one later
  wire [31:0] addr_wide = is4 ? seg_word[127:96] : seg_word[95:64];
  wire [31:0] addr_narrow = hdr4_q ? seg_word[63:32] : seg_word[31:0];
  wire addr_evt = take && ((WIDTH != 64 && sop_any) ||
                           (WIDTH == 64 && hdr_pend_q));
  wire addr_bit = (WIDTH == 64) ? addr_narrow[tlptx_pkg::TLPTX_ADDR_POS]
                                : addr_wide[tlptx_pkg::TLPTX_ADDR_POS];

  // ****************************************************************
  // framing check, segment by segment in bus order
  // ****************************************************************
  always_comb begin
    in_pkt_d = in_pkt_q;
    fault_d = overrun;
    if (take) begin
      for (int s = 0; s < SEGS; s++) begin
        if (TX_PACKET_FIRST[s]) begin
          if (in_pkt_d) fault_d = 1'b1;   // start inside a packet
          in_pkt_d = 1'b1;
        end
        if (TX_PACKET_LAST[s]) begin
          if (!in_pkt_d) fault_d = 1'b1;  // end with nothing open
          in_pkt_d = 1'b0;
        end
      end
      if (!sop_any && !eop_any && !in_pkt_q) fault_d = 1'b1;
      if (SEGS == 2 && !MULTI && TX_PACKET_FIRST[SEGS-1]) begin
        fault_d = 1'b1;
      end
      if (TX_UPPER_HALF_UNUSED != '0 && !eop_any) begin
        fault_d = 1'b1;
      end
      if (sop_any && is_msg && !is4) fault_d = 1'b1;
    end
  end

  // packet state and status flags
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      in_pkt_q <= 1'h0;
      hdr_pend_q <= 1'h0;
      hdr4_q <= 1'h0;
      unal_q <= tlptx_pkg::TLPTX_RST_FLAG;
      fault_q <= tlptx_pkg::TLPTX_RST_FLAG;
    end else begin
      in_pkt_q <= in_pkt_d;
      fault_q <= fault_d;
      if (take) hdr_pend_q <= (WIDTH == 64) && sop_any && !eop_any;
      if (take && sop_any) hdr4_q <= is4;
      if (addr_evt) unal_q <= addr_bit;
    end
  end

  // ****************************************************************
  // buffer towards the transaction layer
  // ****************************************************************
  // every beat taken is kept with its qualifiers; nothing is rewritten
  tlptx_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_buf (
    .clk(CLK),
    .rst(SYS_RST),
    .in_valid(take),
    .in_ready(fifo_in_ready),
    .in_data({TX_PACKET_POISON, TX_UPPER_HALF_UNUSED, TX_PACKET_LAST,
              TX_PACKET_FIRST, TX_STREAM_WORD}),
    .out_valid(OUT_VALID),
    .out_ready(OUT_READY),
    .out_data(head),
    .level(level)
  );

  assign {OUT_POISON, OUT_EMPTY, OUT_LAST, OUT_FIRST, OUT_WORD} = head;
  assign TX_ACCEPT_READY = ready_q;
  assign ADDR_UNALIGNED = unal_q;
  assign FRAME_FAULT = fault_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_credit_ready;
    @(posedge CLK) disable iff (SYS_RST)
      CREDIT_EXHAUSTED |=> !TX_ACCEPT_READY;
  endproperty
  a_credit_ready: assert property (p_credit_ready)
    else $error("ready high after credits ran out");

  property p_space_ready;
    @(posedge CLK) disable iff (SYS_RST)
      TX_ACCEPT_READY |-> ##2 fifo_in_ready;
  endproperty
  a_space_ready: assert property (p_space_ready)
    else $error("promised beat has no room");

  property p_legal_window;
    @(posedge CLK) disable iff (SYS_RST)
      take |-> $past(TX_ACCEPT_READY, 2);
  endproperty
  a_legal_window: assert property (p_legal_window)
    else $error("beat taken outside the ready window");

  property p_back_to_back;
    @(posedge CLK) disable iff (SYS_RST)
      (take && TX_PACKET_LAST[0] && !TX_PACKET_FIRST[0] && in_pkt_q)
      ##1 (take && TX_PACKET_FIRST[0] && !is_msg && SEGS == 1
           && TX_UPPER_HALF_UNUSED == '0) |-> !fault_d;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("start right after end was refused");

  property p_idle_gap;
    @(posedge CLK) disable iff (SYS_RST)
      (take && eop_any && !sop_any && in_pkt_q) ##1 !TX_WORD_VALID
      |=> !in_pkt_q && !FRAME_FAULT;
  endproperty
  a_idle_gap: assert property (p_idle_gap)
    else $error("idle gap after end disturbed framing");

  property p_msg_layout;
    @(posedge CLK) disable iff (SYS_RST)
      (take && sop_any && is_msg && !is4) |=> FRAME_FAULT;
  endproperty
  a_msg_layout: assert property (p_msg_layout)
    else $error("message with three dword header not flagged");

  property p_addr_bit;
    @(posedge CLK) disable iff (SYS_RST)
      addr_evt |=> ADDR_UNALIGNED == $past(addr_bit);
  endproperty
  a_addr_bit: assert property (p_addr_bit)
    else $error("alignment flag does not follow address bit 2");

  property p_empty_end;
    @(posedge CLK) disable iff (SYS_RST)
      (take && TX_UPPER_HALF_UNUSED != '0 && !eop_any) |=> FRAME_FAULT;
  endproperty
  a_empty_end: assert property (p_empty_end)
    else $error("empty outside an end cycle not flagged");

  property p_shared_cycle;
    @(posedge CLK) disable iff (SYS_RST)
      (take && MULTI && in_pkt_q && TX_PACKET_LAST[0]
       && TX_PACKET_FIRST[SEGS-1] && !TX_PACKET_FIRST[0]
       && !TX_PACKET_LAST[SEGS-1]) |=> in_pkt_q;
  endproperty
  a_shared_cycle: assert property (p_shared_cycle)
    else $error("end and start in one cycle lost the new packet");

  c_back_to_back: cover property (@(posedge CLK) disable iff (SYS_RST)
    (take && eop_any) ##1 (take && sop_any));
  c_backpressure: cover property (@(posedge CLK) disable iff (SYS_RST)
    TX_ACCEPT_READY ##1 !TX_ACCEPT_READY ##2 !TX_WORD_VALID);
  c_unaligned: cover property (@(posedge CLK) disable iff (SYS_RST)
    addr_evt && addr_bit);
endmodule

`default_nettype wire

// ==== tlptx_stream_sink_test.sv ====
// bench for the transmit stream sink at 128 bits, single mode,
// with a 64 bit copy driven by hand for the narrow layout.
// assumes the sender model drives the stream; the bench the rest.
`timescale 1ns/1ns
`default_nettype none

// ********
// bench top
// ********
module tlptx_stream_sink_test;
  // clock starts low without an edge, so reset counts whole cycles
  logic clk = 1'h0;
  logic rst, credit, out_ready, first, last, empty, poison, valid;
  logic ready, o_first, o_last, o_empty, o_poison, o_valid, unal, fault;
  logic [127:0] word, o_word;
  logic first64, last64, valid64, rdy64, ov64, unal64, fault64;
  logic [63:0] word64;
  logic [131:0] exp_q[$], got_q[$];
  int num_errors = 0, cmp_count = 0, faults = 0, cyc = 0;
  int faults64 = 0, got64 = 0;

  tlptx_stream_sink #(.WIDTH(128), .DEPTH(16), .MULTI(1'h0)) uut (
    .CLK(clk), .SYS_RST(rst), .TX_STREAM_WORD(word),
    .TX_PACKET_FIRST(first), .TX_PACKET_LAST(last), .TX_WORD_VALID(valid),
    .TX_UPPER_HALF_UNUSED(empty), .TX_PACKET_POISON(poison),
    .TX_ACCEPT_READY(ready), .CREDIT_EXHAUSTED(credit), .OUT_WORD(o_word),
    .OUT_FIRST(o_first), .OUT_LAST(o_last), .OUT_EMPTY(o_empty),
    .OUT_POISON(o_poison), .OUT_VALID(o_valid), .OUT_READY(out_ready),
    .ADDR_UNALIGNED(unal), .FRAME_FAULT(fault));
  tlptx_sender_model sender (.clk(clk), .rst(rst), .ready(ready),
    .word(word), .first(first), .last(last), .empty(empty),
    .poison(poison), .valid(valid));
  // narrow copy of the sink, driven by hand for the 64 bit layout
  tlptx_stream_sink #(.WIDTH(64), .DEPTH(16), .MULTI(1'h0)) uut_w64 (
    .CLK(clk), .SYS_RST(rst), .TX_STREAM_WORD(word64),
    .TX_PACKET_FIRST(first64), .TX_PACKET_LAST(last64),
    .TX_WORD_VALID(valid64), .TX_UPPER_HALF_UNUSED(1'h0),
    .TX_PACKET_POISON(1'h0), .TX_ACCEPT_READY(rdy64),
    .CREDIT_EXHAUSTED(credit), .OUT_WORD(), .OUT_FIRST(), .OUT_LAST(),
    .OUT_EMPTY(), .OUT_POISON(), .OUT_VALID(ov64), .OUT_READY(out_ready),
    .ADDR_UNALIGNED(unal64), .FRAME_FAULT(fault64));

  initial begin
    forever #20 clk = ~clk;
  end
  // collect delivered beats and fault pulses; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (!rst && o_valid === 1'h1 && out_ready)
      got_q.push_back({o_first, o_last, o_empty, o_poison, o_word});
    if (!rst && fault === 1'h1) faults++;
    if (!rst && fault64 === 1'h1) faults64++;
    if (!rst && ov64 === 1'h1 && out_ready) got64++;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end

  // ********
  // compare and report
  // ********
  task automatic chk_flag(string n, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_beat(string n, logic [131:0] e, logic [131:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_count(string n, int e, int g);
    cmp_count++;
    if (g != e) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ********
  // stimulus helpers
  // ********
  task automatic put(logic [131:0] b, bit keep);
    sender.beats.push_back(b);
    if (keep) exp_q.push_back(b);
  endtask
  // two beat packet; header dwords lowest first at bits 31:0
  task automatic pkt(logic [31:0] dw0, logic [31:0] adr, logic emp);
    logic [127:0] h;
    h = dw0[29] ? {adr, 32'h0, 32'h0000_000f, dw0}
        : {32'h0403_0201, adr, 32'h0000_000f, dw0};
    put({4'h8, h}, 1'h1);
    put({2'h1, emp, ~emp, {4{adr}}}, 1'h1);
  endtask
  // wait for the stream to drain, then judge beats and faults
  task automatic settle(int nf);
    int n;
    n = 0;
    while ((sender.beats.size() > 0 || o_valid) && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk_count("fault pulses", nf, faults);
    chk_count("beat count", exp_q.size(), got_q.size());
    foreach (got_q[i])
      if (i < exp_q.size()) chk_beat("beat", exp_q[i], got_q[i]);
    exp_q = {};
    got_q = {};
    faults = 0;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_layout();
    logic [31:0] hd[4] = '{32'h4000_0001, 32'h4000_0001, 32'h6000_0001,
                           32'h7000_0001};
    logic [31:0] adr;
    for (int i = 0; i < 4; i++) begin
      adr = {29'h0000_0200, i[0], 2'h0};
      pkt(hd[i], adr, i[1]);
      settle(0);
      chk_flag("unaligned", adr[2], unal);
    end
    pkt(32'h5000_0001, 32'h0, 1'h0);
    settle(1);
  endtask
  // 64 bit: unaligned three dword, then four dword with no idle cycle
  task automatic t_w64();
    logic [65:0] b[6] = '{{2'h2, 32'h0000_000f, 32'h4000_0001},
                          {2'h0, 32'h0403_0201, 32'h0000_0104},
                          {2'h1, 32'h0c0b_0a09, 32'h0807_0605},
                          {2'h2, 32'h0000_000f, 32'h6000_0001},
                          {2'h0, 32'h0000_0200, 32'h0000_0000},
                          {2'h1, 32'h0807_0605, 32'h0403_0201}};
    chk_flag("ready64 before beats", 1'h1, rdy64);
    foreach (b[i]) begin
      if (i == 3) chk_flag("unaligned64", 1'h1, unal64);
      {first64, last64, word64} = b[i];
      valid64 = 1'h1;
      @(negedge clk);
    end
    valid64 = 1'h0;
    repeat (3) @(negedge clk);
    chk_flag("aligned64", 1'h0, unal64);
    chk_count("fault pulses 64", 0, faults64);
    chk_count("beat count 64", 6, got64);
  endtask
  task automatic t_b2b(int g);
    sender.gap = g;
    repeat (3) pkt(32'h4000_0001, 32'h0000_0100, 1'h1);
    settle(0);
    sender.gap = 0;
  endtask
  task automatic t_bp();
    repeat (4) pkt(32'h6000_0001, 32'h0000_0204, 1'h0);
    @(negedge clk);
    credit = 1'h1;
    @(negedge clk);
    chk_flag("ready after credit", 1'h0, ready);
    repeat (5) @(negedge clk);
    credit = 1'h0;
    settle(0);
    chk_flag("unaligned set", 1'h1, unal);
  endtask
  task automatic t_overrun();
    credit = 1'h1;
    repeat (4) @(negedge clk);
    sender.rude = 1'h1;
    put({4'hc, 128'h0}, 1'h0);
    repeat (4) @(negedge clk);
    sender.rude = 1'h0;
    credit = 1'h0;
    settle(1);
  endtask
  task automatic t_fifo();
    out_ready = 1'h0;
    for (int i = 0; i < 20; i++) put({4'hc, 96'h0, i[31:0]}, 1'h1);
    repeat (30) @(negedge clk);
    chk_flag("ready when full", 1'h0, ready);
    chk_flag("sender held", 1'h1, sender.beats.size() > 0);
    out_ready = 1'h1;
    settle(0);
  endtask
  // reset on a drained stream: ready and every flag must fall
  task automatic t_reset();
    rst = 1'h1;
    repeat (3) @(negedge clk);
    chk_flag("ready in reset", 1'h0, ready);
    chk_flag("out valid in reset", 1'h0, o_valid);
    chk_flag("fault in reset", 1'h0, fault);
    chk_flag("unaligned in reset", 1'h0, unal);
    rst = 1'h0;
    @(negedge clk);
    chk_flag("ready after reset", 1'h1, ready);
  endtask
  // an end with nothing open, then a middle beat while idle
  task automatic t_stray();
    put({4'h4, 128'h0}, 1'h1);
    put({4'h0, 128'h0}, 1'h1);
    settle(2);
  endtask

  initial begin
    credit = 1'h0;
    out_ready = 1'h1;
    {first64, last64, valid64} = 3'h0;
    word64 = 64'h0;
    t_reset();
    t_layout();
    t_w64();
    t_b2b(0);
    t_b2b(3);
    t_bp();
    t_reset();
    t_overrun();
    t_stray();
    t_fifo();
    final_report();
  end
endmodule
`default_nettype wire
